// *** hw/dlv_pkg.sv ***
package dlv_pkg;
   localparam int NCH   = 16;
   localparam int CW    = 12;
   localparam int LEGS  = 3;
   localparam int AW    = 8;
   localparam int DW    = 32;

   // Register byte offsets
   localparam logic [AW-1:0] OFF_ID     = 8'h00;
   localparam logic [AW-1:0] OFF_ALARM  = 8'h04;
   localparam logic [AW-1:0] OFF_LINE   = 8'h08;
   localparam logic [AW-1:0] OFF_LOOP   = 8'h0C;
   localparam logic [AW-1:0] OFF_TH_OP  = 8'h10;
   localparam logic [AW-1:0] OFF_TH_ON  = 8'h14;
   localparam logic [AW-1:0] OFF_TH_SH  = 8'h18;
   localparam logic [AW-1:0] OFF_MASK   = 8'h1C;
   localparam logic [AW-1:0] OFF_CHRST  = 8'h20;
   localparam logic [AW-1:0] OFF_CTRL   = 8'h24;
   localparam logic [AW-1:0] OFF_T_LO   = 8'h28;
   localparam logic [AW-1:0] OFF_T_HI   = 8'h2C;
   localparam logic [AW-1:0] OFF_T_REF  = 8'h30;
   localparam logic [AW-1:0] OFF_MSTAT  = 8'h34;
   localparam logic [AW-1:0] OFF_DISC   = 8'h38;

   // Control and status bit positions
   localparam int CTRL_TEST  = 0;
   localparam int CTRL_FAULT = 1;
   localparam int CTRL_SCAN  = 2;
   localparam int MS_VFAULT  = 0;
   localparam int MS_BUSY    = 1;
   localparam int MS_DONE    = 2;
   localparam int MS_SUPPLY  = 3;
   localparam int MS_MFAULT  = 4;

   // Module type code, value arbitrary
   localparam logic [15:0]   MOD_ID     = 16'h5A3C;

   // Threshold reset values and test levels
   localparam logic [CW-1:0] TH_OP_RST  = 12'h100;
   localparam logic [CW-1:0] TH_ON_RST  = 12'h400;
   localparam logic [CW-1:0] TH_SH_RST  = 12'h700;
   localparam logic [CW-1:0] REF_T_LO   = 12'h000;
   localparam logic [CW-1:0] REF_T_HI   = 12'hFFF;

   // Reference settle time before each comparator capture
   localparam int CLK_MHZ    = 25;
   localparam int SETTLE_NS  = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]    SETTLE_LD  = 8'(SETTLE_CYC - 1);

   typedef enum logic [2:0] {
      ST_OPEN  = 3'b000,
      ST_ONOFF = 3'b001,
      ST_SHORT = 3'b010,
      ST_TLO   = 3'b011,
      ST_THI   = 3'b100
   } dlv_lvl_t;

   typedef struct packed {
      logic          cyc;
      logic          stb;
      logic          we;
      logic [AW-1:0] adr;
      logic [3:0]    sel;
      logic [DW-1:0] dat;
   } dlv_wb_req_t;

   localparam int REQ_W = $bits(dlv_wb_req_t);
endpackage

// *** hw/dlv_vote3.sv ***
`timescale 1ns/1ps
// Bitwise two-of-three voter with an independent self-check
module dlv_vote3 import dlv_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a_i,
   input  wire logic [W-1:0] b_i,
   input  wire logic [W-1:0] c_i,
   output logic      [W-1:0] v_o,
   output logic      [2:0]   disc_o,
   output logic              err_o
);
   logic [W-1:0] ok;

   // Majority of the three legs
   assign v_o = (a_i & b_i) | (b_i & c_i) | (a_i & c_i);

   // Leg disagreeing with the voted word
   assign disc_o = {c_i != v_o, b_i != v_o, a_i != v_o};

   // Check computed from agreement counts, not from the voter gates, so a
   // stuck voter output bit shows up here
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_chk
         assign ok[i] = ((v_o[i] == a_i[i]) && (v_o[i] == b_i[i]))
                     || ((v_o[i] == b_i[i]) && (v_o[i] == c_i[i]))
                     || ((v_o[i] == a_i[i]) && (v_o[i] == c_i[i]));
      end
   endgenerate

   assign err_o = ~&ok;
endmodule

// *** hw/dlv_core.sv ***
// Operation
// - Requests on the three bus legs are majority voted before use.
// - Read data goes out on three independently controlled leg drivers.
// - A voter failure sets the module fault indication.
// - A readable module type code is offered; processors compare it.
// - Loopback word written by processors reads back unchanged.
// - Reference steps through three levels, comparators captured at each.
// - All sixteen comparator states are read and stored.
// - Alarm and line health per channel derive from the three samples.
// - Each channel classifies as tripped, healthy, open or shorted.
// - Test cycle drives two out-of-range levels, reports results and readback.
// - Each channel has a commanded reset output removing loop power.
// - Processor-flagged input circuit fault lights the module fault LED.
// - Green activity LED toggles once per controller scan.
// - Module fault lights red and turns green off.
// - Channel red LED lit when tripped or shorted.
// - Channel yellow LED lit when loop open or shorted.
// - Supply LED lit only with field supply present and regulator good.
// - Status word: channel one in bit 0, channel sixteen in bit 15.
// - Line health bit is one when sound, zero on fault, not latched.
// - Mask suppresses only the line fault LED, not monitoring.
// - Open, on/off and short thresholds are software settable.
`timescale 1ns/1ps
module dlv_core import dlv_pkg::*; (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire dlv_wb_req_t [LEGS-1:0] leg_req_i,
   output logic        [LEGS-1:0]      leg_ack_o,
   output logic        [LEGS-1:0][DW-1:0] leg_dat_o,
   input  wire logic   [NCH-1:0]       cmp_i,
   input  wire logic   [CW-1:0]        ref_rb_i,
   input  wire logic                   field_pwr_i,
   input  wire logic                   reg_ok_i,
   output logic        [CW-1:0]        ref_o,
   output logic        [NCH-1:0]       chan_rst_o,
   output logic        [NCH-1:0]       led_alarm_o,
   output logic        [NCH-1:0]       led_line_o,
   output logic                        led_act_o,
   output logic                        led_fault_o,
   output logic                        led_pwr_o
);
   dlv_wb_req_t     v;
   logic [2:0]      disc;
   logic            vote_err;
   logic            vreq, wr_en;
   logic [DW-1:0]   rdata;

   // Voting of the whole request word
   dlv_vote3 #(.W(REQ_W)) u_vote (
      .a_i    (leg_req_i[0]),
      .b_i    (leg_req_i[1]),
      .c_i    (leg_req_i[2]),
      .v_o    (v),
      .disc_o (disc),
      .err_o  (vote_err)
   );

   // Bus state
   logic                    ack_reg, ack_next;
   logic [LEGS-1:0]         lack_reg, lack_next;
   logic [LEGS-1:0][DW-1:0] ldat_reg, ldat_next;

   assign vreq  = v.cyc & v.stb;
   assign wr_en = vreq & v.we & ack_reg;  // Commit at the edge the master sees ack

   // Software registers
   logic [DW-1:0]  loop_reg, loop_next;
   logic [CW-1:0]  thop_reg, thop_next, thon_reg, thon_next, thsh_reg, thsh_next;
   logic [NCH-1:0] mask_reg, mask_next, crst_reg, crst_next;
   logic           test_reg, test_next, sfault_reg, sfault_next;
   logic           act_reg, act_next, vflt_reg, vflt_next, done_reg, done_next;
   logic [2:0]     disc_reg, disc_next;
   logic           test_end;
   logic           mfault;

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
                                           input logic [DW-1:0] n,
                                           input logic [3:0]    s);
      logic [DW-1:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Field side sequencer state
   dlv_lvl_t       lvl_reg, lvl_next;
   logic [7:0]     cnt_reg, cnt_next;
   logic [CW-1:0]  ref_reg, ref_next;
   logic [NCH-1:0] s_op_reg, s_op_next, s_on_reg, s_on_next;
   logic [NCH-1:0] tlo_reg, tlo_next, thi_reg, thi_next;
   logic [CW-1:0]  rblo_reg, rblo_next, rbhi_reg, rbhi_next;
   logic [NCH-1:0] alarm_reg, alarm_next, lineok_reg, lineok_next;
   logic [NCH-1:0] short_reg, short_next;
   logic [NCH-1:0][1:0] cond;
   logic [NCH-1:0] c_alarm, c_short, c_open;

   // Read mux on the voted address
   always_comb begin
      case (v.adr)
         OFF_ID:    rdata = {16'h0000, MOD_ID};
         OFF_ALARM: rdata = {16'h0000, alarm_reg};
         OFF_LINE:  rdata = {16'h0000, lineok_reg};
         OFF_LOOP:  rdata = loop_reg;
         OFF_TH_OP: rdata = {20'h00000, thop_reg};
         OFF_TH_ON: rdata = {20'h00000, thon_reg};
         OFF_TH_SH: rdata = {20'h00000, thsh_reg};
         OFF_MASK:  rdata = {16'h0000, mask_reg};
         OFF_CHRST: rdata = {16'h0000, crst_reg};
         OFF_CTRL:  rdata = {29'h00000000, act_reg, sfault_reg, test_reg};
         OFF_T_LO:  rdata = {16'h0000, tlo_reg};
         OFF_T_HI:  rdata = {16'h0000, thi_reg};
         OFF_T_REF: rdata = {4'h0, rbhi_reg, 4'h0, rblo_reg};
         OFF_MSTAT: rdata = {27'h0000000, mfault, field_pwr_i & reg_ok_i,
                             done_reg, test_reg, vflt_reg};
         OFF_DISC:  rdata = {29'h00000000, disc_reg};
         default:   rdata = 32'h00000000;                        // Unmapped reads zero
      endcase
   end

   // Ack and per-leg drivers: each leg answers only on its own strobe
   always_comb begin
      ack_next  = vreq & ~ack_reg;
      lack_next = '0;
      ldat_next = ldat_reg;
      for (int l = 0; l < LEGS; l++) begin
         lack_next[l] = ack_next & leg_req_i[l].cyc & leg_req_i[l].stb;
         if (ack_next) begin
            ldat_next[l] = rdata;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         lack_reg <= '0;
         ldat_reg <= '0;
      end else begin
         ack_reg  <= ack_next;
         lack_reg <= lack_next;
         ldat_reg <= ldat_next;
      end
   end

   assign leg_ack_o = lack_reg;
   assign leg_dat_o = ldat_reg;

   // Register writes; hardware sets win over software clears
   always_comb begin
      loop_next   = loop_reg;
      thop_next   = thop_reg;
      thon_next   = thon_reg;
      thsh_next   = thsh_reg;
      mask_next   = mask_reg;
      crst_next   = crst_reg;
      test_next   = test_reg;
      sfault_next = sfault_reg;
      act_next    = act_reg;
      vflt_next   = vflt_reg;
      done_next   = done_reg;
      disc_next   = disc_reg;
      if (wr_en) begin
         case (v.adr)
            OFF_LOOP:  loop_next = merge(loop_reg, v.dat, v.sel);
            OFF_TH_OP: thop_next = v.dat[CW-1:0];
            OFF_TH_ON: thon_next = v.dat[CW-1:0];
            OFF_TH_SH: thsh_next = v.dat[CW-1:0];
            OFF_MASK:  mask_next = v.dat[NCH-1:0];
            OFF_CHRST: crst_next = v.dat[NCH-1:0];
            OFF_CTRL: begin
               test_next   = test_reg | v.dat[CTRL_TEST];
               sfault_next = v.dat[CTRL_FAULT];
               if (v.dat[CTRL_SCAN]) begin
                  act_next = ~act_reg;
               end
            end
            OFF_MSTAT: begin
               if (v.dat[MS_VFAULT]) vflt_next = 1'b0;
               if (v.dat[MS_DONE]) done_next = 1'b0;
            end
            OFF_DISC:  disc_next = disc_reg & ~v.dat[2:0];
            default: ;
         endcase
      end
      if (test_end) begin
         test_next = 1'b0;
         done_next = 1'b1;
      end
      if (vreq && vote_err) begin
         vflt_next = 1'b1;
      end
      if (vreq) begin
         disc_next = disc_next | disc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_reg   <= '0;
         thop_reg   <= TH_OP_RST;
         thon_reg   <= TH_ON_RST;
         thsh_reg   <= TH_SH_RST;
         mask_reg   <= '0;
         crst_reg   <= '0;
         test_reg   <= 1'b0;
         sfault_reg <= 1'b0;
         act_reg    <= 1'b0;
         vflt_reg   <= 1'b0;
         done_reg   <= 1'b0;
         disc_reg   <= '0;
      end else begin
         loop_reg   <= loop_next;
         thop_reg   <= thop_next;
         thon_reg   <= thon_next;
         thsh_reg   <= thsh_next;
         mask_reg   <= mask_next;
         crst_reg   <= crst_next;
         test_reg   <= test_next;
         sfault_reg <= sfault_next;
         act_reg    <= act_next;
         vflt_reg   <= vflt_next;
         done_reg   <= done_next;
         disc_reg   <= disc_next;
      end
   end

   assign mfault = vflt_reg | sfault_reg;

   // Per-channel classification from the two captured samples and live cmp_i
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_cls
         assign cond[ch] = !s_op_reg[ch] ? 2'h2 :                     // Open
                           !s_on_reg[ch] ? 2'h0 :                     // Healthy
                           !cmp_i[ch]    ? 2'h1 : 2'h3;
         assign c_alarm[ch] = (cond[ch] == 2'h1);
         assign c_open[ch]  = (cond[ch] == 2'h2);
         assign c_short[ch] = (cond[ch] == 2'h3);
      end
   endgenerate

   // Reference stepping: settle, capture, next level; test sweep on request
   always_comb begin
      lvl_next    = lvl_reg;
      cnt_next    = cnt_reg - 8'h01;
      ref_next    = ref_reg;
      s_op_next   = s_op_reg;
      s_on_next   = s_on_reg;
      tlo_next    = tlo_reg;
      thi_next    = thi_reg;
      rblo_next   = rblo_reg;
      rbhi_next   = rbhi_reg;
      alarm_next  = alarm_reg;
      lineok_next = lineok_reg;
      short_next  = short_reg;
      test_end    = 1'b0;
      if (cnt_reg == 8'h00) begin
         cnt_next = SETTLE_LD;
         case (lvl_reg)
            ST_OPEN: begin
               s_op_next = cmp_i;
               lvl_next  = ST_ONOFF;
               ref_next  = thon_reg;
            end
            ST_ONOFF: begin
               s_on_next = cmp_i;
               lvl_next  = ST_SHORT;
               ref_next  = thsh_reg;
            end
            ST_SHORT: begin
               // Short level is classified live from cmp_i, so all three
               // samples belong to this sweep and no stale one leaks in
               alarm_next  = c_alarm;
               lineok_next = ~(c_open | c_short);
               short_next  = c_short;
               lvl_next    = test_reg ? ST_TLO : ST_OPEN;
               ref_next    = test_reg ? REF_T_LO : thop_reg;
            end
            ST_TLO: begin
               tlo_next  = cmp_i;
               rblo_next = ref_rb_i;
               lvl_next  = ST_THI;
               ref_next  = REF_T_HI;
            end
            ST_THI: begin
               thi_next  = cmp_i;
               rbhi_next = ref_rb_i;
               test_end  = 1'b1;
               lvl_next  = ST_OPEN;
               ref_next  = thop_reg;
            end
            default: begin
               lvl_next = ST_OPEN;
               ref_next = thop_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_reg    <= ST_OPEN;
         cnt_reg    <= SETTLE_LD;
         ref_reg    <= TH_OP_RST;
         s_op_reg   <= '0;
         s_on_reg   <= '0;
         tlo_reg    <= '0;
         thi_reg    <= '0;
         rblo_reg   <= '0;
         rbhi_reg   <= '0;
         alarm_reg  <= '0;
         lineok_reg <= '1;
         short_reg  <= '0;
      end else begin
         lvl_reg    <= lvl_next;
         cnt_reg    <= cnt_next;
         ref_reg    <= ref_next;
         s_op_reg   <= s_op_next;
         s_on_reg   <= s_on_next;
         tlo_reg    <= tlo_next;
         thi_reg    <= thi_next;
         rblo_reg   <= rblo_next;
         rbhi_reg   <= rbhi_next;
         alarm_reg  <= alarm_next;
         lineok_reg <= lineok_next;
         short_reg  <= short_next;
      end
   end

   // Indicators, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_alarm_o <= '0;
         led_line_o  <= '0;
         led_act_o   <= 1'b0;
         led_fault_o <= 1'b0;
         led_pwr_o   <= 1'b0;
      end else begin
         led_alarm_o <= alarm_reg | short_reg;
         led_line_o  <= ~lineok_reg & ~mask_reg;
         led_act_o   <= act_reg & ~mfault;
         led_fault_o <= mfault;
         led_pwr_o   <= field_pwr_i & reg_ok_i;
      end
   end

   assign ref_o      = ref_reg;
   assign chan_rst_o = crst_reg;

   property p_vote_adr;
      @(posedge clk_i) disable iff (rst_i)
      (leg_req_i[0].adr == leg_req_i[1].adr) |-> (v.adr == leg_req_i[0].adr);
   endproperty
   a_vote_adr: assert property (p_vote_adr) else $error("voted address wrong");

   property p_leg_ack;
      @(posedge clk_i) disable iff (rst_i)
      leg_ack_o[1] |-> $past(leg_req_i[1].stb) ##1 !leg_ack_o[1];
   endproperty
   a_leg_ack: assert property (p_leg_ack) else $error("leg ack not own");

   property p_vflt;
      @(posedge clk_i) disable iff (rst_i)
      (vreq && vote_err) |=> vflt_reg ##1 led_fault_o;
   endproperty
   a_vflt: assert property (p_vflt) else $error("voter fault missed");

   property p_id;
      @(posedge clk_i) disable iff (rst_i)
      (ack_next && v.adr == OFF_ID) |=> (leg_dat_o[0] == {16'h0000, MOD_ID});
   endproperty
   a_id: assert property (p_id) else $error("id read wrong");

   property p_loop;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && v.adr == OFF_LOOP && v.sel == 4'hF) |=> loop_reg == $past(v.dat);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback lost");

   property p_step;
      @(posedge clk_i) disable iff (rst_i)
      (lvl_reg == ST_OPEN && cnt_reg == 8'h00) |=> (lvl_reg == ST_ONOFF && ref_o == thon_reg);
   endproperty
   a_step: assert property (p_step) else $error("reference step wrong");

   property p_thi;
      @(posedge clk_i) disable iff (rst_i)
      (lvl_reg == ST_THI) |-> (ref_o == REF_T_HI);
   endproperty
   a_thi: assert property (p_thi) else $error("test level wrong");

   property p_red;
      @(posedge clk_i) disable iff (rst_i)
      led_fault_o |-> !led_act_o;
   endproperty
   a_red: assert property (p_red) else $error("green on in fault");

   property p_pwr;
      @(posedge clk_i) disable iff (rst_i)
      !(field_pwr_i && reg_ok_i) |=> !led_pwr_o;
   endproperty
   a_pwr: assert property (p_pwr) else $error("supply led wrong");
endmodule

// *** bench/dlv_proc_model.sv ***
`timescale 1ns/1ps
// Three processor legs sending one access; one leg may carry spoiled fields
module dlv_proc_model import dlv_pkg::*; (
   input  wire logic                    clk_i,
   input  wire logic [LEGS-1:0]         leg_ack_i,
   output dlv_wb_req_t [LEGS-1:0]       leg_req_o
);
   logic tmo;

   initial begin
      leg_req_o = '0;
      tmo = 1'b0;
   end

   // Classic cycle; leg bad gets inverted address and data to test the voter
   task automatic access(input logic we, input logic [AW-1:0] adr,
                         input logic [DW-1:0] dat, input int bad);
      dlv_wb_req_t r;
      int          n;
      n = 0;
      @(posedge clk_i);
      for (int l = 0; l < LEGS; l++) begin
         r = '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
         if (l == bad) begin
            r.adr = ~adr;
            r.dat = ~dat;
         end
         leg_req_o[l] <= r;
      end
      // Request stands until ack is sampled at a rising edge
      do begin
         @(posedge clk_i);
         n++;
      end while (leg_ack_i === 3'b000 && n < 64);
      tmo = (leg_ack_i === 3'b000);
      leg_req_o <= '0;
   endtask
endmodule

// *** bench/detector_loop_status_voter_tb_top.sv ***
`timescale 1ns/1ps
module detector_loop_status_voter_tb_top import dlv_pkg::*;;
   typedef struct packed {
      logic          rd;
      logic [DW-1:0] dat;
   } dlv_exp_t;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   dlv_wb_req_t [LEGS-1:0] leg_req;
   logic [LEGS-1:0]        leg_ack_o;
   logic [LEGS-1:0][DW-1:0] leg_dat_o;
   logic [NCH-1:0]         cmp_i = '0;
   logic [CW-1:0]          ref_rb_i = '0;
   logic                   field_pwr_i = 1'b1;
   logic                   reg_ok_i = 1'b1;
   logic [CW-1:0]          ref_o;
   logic [NCH-1:0]         chan_rst_o;
   logic [NCH-1:0]         led_alarm_o;
   logic [NCH-1:0]         led_line_o;
   logic                   led_act_o;
   logic                   led_fault_o;
   logic                   led_pwr_o;
   logic [CW-1:0]          cur [NCH];
   logic [CW-1:0]          lvl [4] = '{12'h050, 12'h200, 12'h600, 12'h900};
   logic [CW-1:0]          th_r [3] = '{TH_OP_RST, TH_ON_RST, TH_SH_RST};
   logic [CW-1:0]          th_n [3] = '{12'h0C0, 12'h480, 12'h780};
   logic [31:0]            rng = 32'h9951;
   logic [NCH-1:0]         opn, shr, alm, msk;
   dlv_exp_t               expq [$];
   int                     bad_count = 0;
   int                     num_checks = 0;

   always #20 clk_i = ~clk_i;

   dlv_core u_dlv_core (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .leg_req_i   (leg_req),
      .leg_ack_o   (leg_ack_o),
      .leg_dat_o   (leg_dat_o),
      .cmp_i       (cmp_i),
      .ref_rb_i    (ref_rb_i),
      .field_pwr_i (field_pwr_i),
      .reg_ok_i    (reg_ok_i),
      .ref_o       (ref_o),
      .chan_rst_o  (chan_rst_o),
      .led_alarm_o (led_alarm_o),
      .led_line_o  (led_line_o),
      .led_act_o   (led_act_o),
      .led_fault_o (led_fault_o),
      .led_pwr_o   (led_pwr_o)
   );

   dlv_proc_model proc_m (
      .clk_i     (clk_i),
      .leg_ack_i (leg_ack_o),
      .leg_req_o (leg_req)
   );

   // Field loops: comparator on when loop current exceeds the reference
   always @(posedge clk_i) begin
      for (int c = 0; c < NCH; c++) begin
         cmp_i[c] <= (cur[c] > ref_o);
      end
      ref_rb_i <= ref_o;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_ack(input logic [LEGS-1:0] got, input logic [LEGS-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic note(input string s);
      $display("test %s ends, checks %0d mismatches %0d", s, num_checks, bad_count);
   endtask

   // Driver notes the expected answer, then runs the access on all legs
   task automatic bus(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [DW-1:0] exp, input int bad);
      expq.push_back('{rd: !we, dat: exp});
      proc_m.access(we, a, d, bad);
      if (proc_m.tmo) begin
         bad_count++;
         complete_run();
      end
   endtask

   // Watcher retires the oldest note on every acked cycle
   always @(posedge clk_i) begin
      dlv_exp_t e;
      if (!rst_i && leg_ack_o !== 3'b000) begin
         e = '{rd: 1'b0, dat: '0};
         if (expq.size() > 0) begin
            e = expq.pop_front();
         end else begin
            // An ack nobody asked for is a fault in itself
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, leg_ack_o, 3'b000);
         end
         cmp_ack(leg_ack_o, 3'b111);
         for (int l = 0; l < LEGS && e.rd; l++) begin
            cmp_word(leg_dat_o[l], e.dat);
         end
      end
   end

   initial begin
      for (int c = 0; c < NCH; c++) begin
         cur[c] = 12'h200;
      end
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFF_ID, '0, {16'h0000, MOD_ID}, 0);
      bus(1'b0, 8'h3C, '0, 32'h0, LEGS);
      bus(1'b0, OFF_LINE, '0, 32'h0000_FFFF, 1);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, OFF_TH_OP + 8'(4 * i), '0, {20'h0, th_r[i]}, LEGS);
         bus(1'b1, OFF_TH_OP + 8'(4 * i), {20'h0, th_n[i]}, '0, i);
         bus(1'b0, OFF_TH_OP + 8'(4 * i), '0, {20'h0, th_n[i]}, 2 - i);
      end
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         bus(1'b1, OFF_LOOP, rng, '0, i);
         bus(1'b0, OFF_LOOP, '0, rng, 3 - i);
      end
      bus(1'b0, OFF_DISC, '0, 32'h7, LEGS);
      bus(1'b1, OFF_DISC, 32'h7, '0, LEGS);
      bus(1'b0, OFF_DISC, '0, 32'h0, LEGS);
      note("bus");
      // Random class per channel: open, healthy, tripped, shorted
      rng = xs(rng);
      msk = rng[15:0];
      bus(1'b1, OFF_MASK, {16'h0, msk}, '0, LEGS);
      rng = xs(rng);
      for (int c = 0; c < NCH; c++) begin
         cur[c] = lvl[rng[2*c +: 2]];
         opn[c] = (rng[2*c +: 2] == 2'd0);
         alm[c] = (rng[2*c +: 2] == 2'd2);
         shr[c] = (rng[2*c +: 2] == 2'd3);
      end
      repeat (450) @(posedge clk_i);
      cmp_word({16'h0, led_alarm_o}, {16'h0, alm | shr});
      cmp_word({16'h0, led_line_o}, {16'h0, (opn | shr) & ~msk});
      bus(1'b0, OFF_LINE, '0, {16'h0, ~(opn | shr)}, 0);
      bus(1'b0, OFF_ALARM, '0, {16'h0, alm}, 2);
      note("classify");
      rng = xs(rng);
      bus(1'b1, OFF_CHRST, {16'h0, rng[15:0]}, '0, 1);
      bus(1'b0, OFF_CHRST, '0, {16'h0, rng[15:0]}, LEGS);
      cmp_word({16'h0, chan_rst_o}, {16'h0, rng[15:0]});
      bus(1'b1, OFF_CTRL, DW'(1) << CTRL_SCAN, '0, LEGS);
      repeat (2) @(posedge clk_i);
      cmp_word({30'h0, led_act_o, led_fault_o}, 32'h2);
      bus(1'b1, OFF_CTRL, DW'(1) << CTRL_FAULT, '0, LEGS);
      repeat (2) @(posedge clk_i);
      cmp_word({30'h0, led_act_o, led_fault_o}, 32'h1);
      bus(1'b1, OFF_CTRL, '0, '0, LEGS);
      for (int i = 0; i < 4; i++) begin
         field_pwr_i <= i[0];
         reg_ok_i <= i[1];
         repeat (3) @(posedge clk_i);
         cmp_word({31'h0, led_pwr_o}, {31'h0, i[0] & i[1]});
      end
      note("outputs");
      bus(1'b1, OFF_CTRL, DW'(1) << CTRL_TEST, '0, LEGS);
      repeat (500) @(posedge clk_i);
      bus(1'b0, OFF_CTRL, '0, DW'(1) << CTRL_SCAN, LEGS);
      bus(1'b0, OFF_T_LO, '0, 32'h0000_FFFF, 0);
      bus(1'b0, OFF_T_HI, '0, 32'h0, 1);
      bus(1'b0, OFF_T_REF, '0, {4'h0, REF_T_HI, 4'h0, REF_T_LO}, 2);
      // Discrepant legs must not have raised the voter fault
      bus(1'b0, OFF_MSTAT, '0, (DW'(1) << MS_DONE) | (DW'(1) << MS_SUPPLY), 0);
      bus(1'b1, OFF_MSTAT, DW'(1) << MS_DONE, '0, LEGS);
      bus(1'b0, OFF_MSTAT, '0, DW'(1) << MS_SUPPLY, 1);
      note("selftest");
      // Let the watcher retire the last answer before the verdict
      repeat (2) @(posedge clk_i);
      if (expq.size() != 0) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, expq.size(), 0);
      end
      complete_run();
   end
endmodule
